// ===== logic/asc_pkg.sv
// package: register map, field positions, reset values and timing for the converter control block
package asc_pkg;
    // ------------------------------------------------------------
    // register indices (printed offsets are not multiples of four)
    // ------------------------------------------------------------
    localparam logic [3:0]  IDX_CONTROL    = 4'h1;
    localparam logic [3:0]  IDX_STATUS     = 4'h2;
    localparam logic [3:0]  IDX_GAIN       = 4'h4;
    localparam logic [3:0]  IDX_THRESHOLD  = 4'h5;
    localparam logic [3:0]  IDX_RESULT     = 4'h6;
    localparam logic [3:0]  IDX_PINS       = 4'h7;
    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int          CTL_RD_THRESH  = 14;
    localparam int          CTL_RD_GAIN    = 13;
    localparam int          CTL_RD_STATUS  = 11;
    localparam int          CTL_SYNC       = 9;
    localparam int          CTL_BYPASS_REF = 7;
    localparam int          CTL_POWER_DOWN = 3;
    localparam int          CTL_LOW_POWER  = 2;
    localparam int          CTL_REFBUF_OFF = 1;
    localparam int          CTL_AMPLIFIER_DISABLE    = 0;
    localparam logic [15:0] CTL_WRITE_MASK = 16'h6a8f;
    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int          STS_PART       = 15;
    localparam int          STS_SETTLED    = 10;
    localparam int          STS_LOW_POWER  = 9;
    localparam int          STS_OVERRANGE  = 8;
    localparam int          STS_REFBUF_OFF = 4;
    localparam int          STS_AMPLIFIER_DISABLE    = 3;
    localparam int          STS_DEC        = 0;
    localparam logic [15:0] STS_FIXED      = 16'h4840;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CONTROL    = 16'h0000;
    localparam logic [15:0] RST_GAIN       = 16'ha000;
    localparam logic [15:0] RST_THRESHOLD  = 16'hcccc;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS  = 40;
    localparam int          SETTLE_US      = 100;
    localparam int          SETTLE_CYCLES  = (SETTLE_US * 1000) / CLK_PERIOD_NS;
    localparam int          SYNC_MIN_CYC   = 4;
    // ------------------------------------------------------------
    // read selection for the next result read
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ASC_SEL_DATA, ASC_SEL_THRESH, ASC_SEL_GAIN, ASC_SEL_STATUS} asc_sel_e;
endpackage

// ===== logic/asc_settle_if.sv
// interface: settling timer control between the register block and its timer
`timescale 1ns/10ps
`default_nettype none
interface asc_settle_if;
    logic restart;
    logic hold;
    logic settled;
    modport ctrl  (output restart, output hold, input settled);
    modport timer (input restart, input hold, output settled);
endinterface
`default_nettype wire

// ===== logic/asc_settle_timer.sv
// settling timer: counts the filter settling interval after start or synchronization
`timescale 1ns/10ps
`default_nettype none
module asc_settle_timer
    import asc_pkg::*;
#(
    parameter int SETTLE_CNT = SETTLE_CYCLES
)
(
    input  wire logic   hclk,
    input  wire logic   hresetn,
    asc_settle_if.timer st
);
    logic [23:0] cnt_ff;
    logic [23:0] nxt_cnt;
    logic        done_ff;
    logic        nxt_done;

    always_comb
    begin
        nxt_cnt  = cnt_ff;
        nxt_done = done_ff;
        if (st.restart)
        begin
            nxt_cnt  = 24'h000000;
            nxt_done = 1'b0;
        end
        else if (!st.hold && !done_ff)
        begin
            if (cnt_ff >= 24'(SETTLE_CNT - 1))
                nxt_done = 1'b1;
            else
                nxt_cnt = cnt_ff + 24'h000001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_ff  <= 24'h000000;
            done_ff <= 1'b0;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    assign st.settled = done_ff;
endmodule // asc_settle_timer
`default_nettype wire

// ===== logic/asc_control.sv
// top: converter start-up and control register block behind an ahb-lite slave
// ------------------------------------------------------------
// Function
// - after start-up data is scaled and checked with default gain and threshold
// - results before settling are invalid; settled flag marks valid data
// - gain and threshold registers are writable and read back
// - a write stores its low 16 bits in gain or threshold, masked in control; other indices ignore it
// - control register sits at index 1 and resets to zero
// - control fields at bits 14,13,11,9,7,3,2,1,0; others read zero
// - read-threshold bit makes the next result read return the threshold
// - bits 14 to 11 and bit 9 clear themselves after taking effect
// - the sync bit starts filter synchronization like the sync pulse
// - settled flag sits at status bit 10, mirroring the filter_valid_flag output
// ------------------------------------------------------------
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module asc_control
    import asc_pkg::*;
#(
    parameter int        SETTLE_CNT = SETTLE_CYCLES,
    parameter logic      PART_BIT   = 1'b1  // arbitrary value
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        sync_n,
    input  wire logic        overrange_in,
    input  wire logic        dec_rate_128,
    input  wire logic [15:0] conv_result,
    output logic      [15:0] gain_value,
    output logic      [15:0] threshold_value,
    output logic             filter_valid_flag,
    output logic             power_down_bit,
    output logic             low_power_flag,
    output logic             ref_bypass,
    output logic             ref_buffer_off,
    output logic             amplifier_disable,
    output logic             filter_sync_pulse
);
    // ------------------------------------------------------------
    // sync pin: three flops, a change counts once stages two and three agree
    // ------------------------------------------------------------
    logic [2:0] sync_sh_ff;
    logic [2:0] nxt_sync_sh;
    logic       sync_lvl_ff;
    logic       nxt_sync_lvl;

    always_comb
    begin
        nxt_sync_sh  = {sync_sh_ff[1:0], sync_n};
        nxt_sync_lvl = sync_lvl_ff;
        if (sync_sh_ff[1] == sync_sh_ff[2])
            nxt_sync_lvl = sync_sh_ff[2];
    end

    // ------------------------------------------------------------
    // bus and register state
    // ------------------------------------------------------------
    logic        wr_pend_ff,  nxt_wr_pend;
    logic        rd_pend_ff,  nxt_rd_pend;
    logic [3:0]  idx_ff,      nxt_idx;
    logic [15:0] ctl_ff,      nxt_ctl;
    logic [15:0] gain_ff,     nxt_gain;
    logic [15:0] thr_ff,      nxt_thr;
    asc_sel_e    sel_ff,      nxt_sel;
    logic [31:0] rdata_ff,    nxt_rdata;
    logic        sync_req;
    logic [15:0] status_word;
    logic        addr_ok;
    asc_settle_if st ();

    assign addr_ok = (haddr[31:6] == 26'h0000000) && (haddr[1:0] == 2'b00);

    // low level on the filtered pin restarts filtering; min width is the host's job
    assign sync_req = !sync_lvl_ff || ctl_ff[CTL_SYNC];

    always_comb
    begin
        status_word                 = STS_FIXED;
        status_word[STS_PART]       = PART_BIT;
        status_word[STS_SETTLED]    = st.settled;
        status_word[STS_LOW_POWER]  = ctl_ff[CTL_LOW_POWER];
        status_word[STS_OVERRANGE]  = overrange_in;
        status_word[STS_REFBUF_OFF] = ctl_ff[CTL_REFBUF_OFF];
        status_word[STS_AMPLIFIER_DISABLE]    = ctl_ff[CTL_AMPLIFIER_DISABLE];
        status_word[STS_DEC]        = dec_rate_128;
    end

    always_comb
    begin
        nxt_wr_pend = 1'b0;
        nxt_rd_pend = 1'b0;
        nxt_idx     = idx_ff;
        nxt_ctl     = ctl_ff;
        nxt_gain    = gain_ff;
        nxt_thr     = thr_ff;
        nxt_sel     = sel_ff;
        nxt_rdata   = rdata_ff;
        // self-clearing bits live one cycle once taken into effect
        nxt_ctl[CTL_SYNC] = 1'b0;
        if (ctl_ff[CTL_RD_THRESH])
            nxt_sel = ASC_SEL_THRESH;
        else if (ctl_ff[CTL_RD_GAIN])
            nxt_sel = ASC_SEL_GAIN;
        else if (ctl_ff[CTL_RD_STATUS])
            nxt_sel = ASC_SEL_STATUS;
        nxt_ctl[CTL_RD_THRESH:CTL_RD_STATUS] = 4'h0;
        // data phase of a write
        if (wr_pend_ff)
        begin
            unique case (idx_ff)
                IDX_CONTROL:   nxt_ctl  = hwdata[15:0] & CTL_WRITE_MASK;
                IDX_GAIN:      nxt_gain = hwdata[15:0];
                IDX_THRESHOLD: nxt_thr  = hwdata[15:0];
                default:       nxt_ctl  = nxt_ctl;
            endcase
        end
        // address phase
        if (hsel && hready && htrans[1])
        begin
            nxt_idx     = haddr[5:2];
            nxt_wr_pend = hwrite && addr_ok;
            nxt_rd_pend = !hwrite;
            nxt_rdata   = 32'h00000000;
            if (!hwrite && addr_ok)
            begin
                unique case (haddr[5:2])
                    IDX_CONTROL:   nxt_rdata = {16'h0000, ctl_ff};
                    IDX_STATUS:    nxt_rdata = {16'h0000, status_word};
                    IDX_GAIN:      nxt_rdata = {16'h0000, gain_ff};
                    IDX_THRESHOLD: nxt_rdata = {16'h0000, thr_ff};
                    IDX_RESULT:
                    begin
                        // redirected read consumes the selection
                        unique case (sel_ff)
                            ASC_SEL_THRESH: nxt_rdata = {16'h0000, thr_ff};
                            ASC_SEL_GAIN:   nxt_rdata = {16'h0000, gain_ff};
                            ASC_SEL_STATUS: nxt_rdata = {16'h0000, status_word};
                            ASC_SEL_DATA:   nxt_rdata = {16'h0000, conv_result};
                        endcase
                        nxt_sel = ASC_SEL_DATA;
                    end
                    IDX_PINS:      nxt_rdata = {31'h00000000, sync_lvl_ff};
                    default:       nxt_rdata = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync_sh_ff  <= 3'h7;
            sync_lvl_ff <= 1'b1;
            wr_pend_ff  <= 1'b0;
            rd_pend_ff  <= 1'b0;
            idx_ff      <= 4'h0;
            ctl_ff      <= RST_CONTROL;
            gain_ff     <= RST_GAIN;
            thr_ff      <= RST_THRESHOLD;
            sel_ff      <= ASC_SEL_DATA;
            rdata_ff    <= 32'h00000000;
        end
        else
        begin
            sync_sh_ff  <= nxt_sync_sh;
            sync_lvl_ff <= nxt_sync_lvl;
            wr_pend_ff  <= nxt_wr_pend;
            rd_pend_ff  <= nxt_rd_pend;
            idx_ff      <= nxt_idx;
            ctl_ff      <= nxt_ctl;
            gain_ff     <= nxt_gain;
            thr_ff      <= nxt_thr;
            sel_ff      <= nxt_sel;
            rdata_ff    <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // settling timer: held in power-down, restarted by either sync source
    // ------------------------------------------------------------
    assign st.restart = sync_req;
    assign st.hold    = ctl_ff[CTL_POWER_DOWN];

    asc_settle_timer #(
        .SETTLE_CNT (SETTLE_CNT)
    ) u_settle (
        .hclk    (hclk),
        .hresetn (hresetn),
        .st      (st)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hrdata            = rdata_ff;
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign gain_value        = gain_ff;
    assign threshold_value   = thr_ff;
    assign filter_valid_flag = st.settled;
    assign power_down_bit    = ctl_ff[CTL_POWER_DOWN];
    assign low_power_flag    = ctl_ff[CTL_LOW_POWER];
    assign ref_bypass        = ctl_ff[CTL_BYPASS_REF];
    assign ref_buffer_off    = ctl_ff[CTL_REFBUF_OFF];
    assign amplifier_disable = ctl_ff[CTL_AMPLIFIER_DISABLE];
    assign filter_sync_pulse = sync_req;
endmodule // asc_control
`default_nettype wire

// ===== verification/asc_control_sva.sv
// checker: bus answers and control-bit timing of the converter control block
`timescale 1ns/10ps
`default_nettype none
module asc_control_sva
    import asc_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        sync_n,
    input wire logic [15:0] gain_value,
    input wire logic [15:0] threshold_value,
    input wire logic        filter_valid_flag,
    input wire logic        power_down_bit,
    input wire logic        low_power_flag,
    input wire logic        ref_bypass,
    input wire logic        ref_buffer_off,
    input wire logic        amplifier_disable,
    input wire logic        filter_sync_pulse
);
    // ----------------------------------------
    // data-phase trackers
    // ----------------------------------------
    logic take;
    logic wr_ctl_ff, rd_ff, rd_ctl_ff, rd_sts_ff;
    assign take = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            {wr_ctl_ff, rd_ff, rd_ctl_ff, rd_sts_ff} <= 4'h0;
        end
        else
        begin
            wr_ctl_ff <= take && hwrite && haddr == 32'h4;
            rd_ff     <= take && !hwrite;
            rd_ctl_ff <= take && !hwrite && haddr == 32'h4;
            rd_sts_ff <= take && !hwrite && haddr == 32'h8;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait okay");
    a_reset_defaults: assert property ($rose(hresetn) |-> gain_value == RST_GAIN
        && threshold_value == RST_THRESHOLD && !filter_valid_flag && !power_down_bit)
        else $error("register outputs not at defaults after reset");
    a_ctl_fields: assert property (wr_ctl_ff |=> {ref_bypass, 3'h0, power_down_bit,
        low_power_flag, ref_buffer_off, amplifier_disable} == ($past(hwdata[7:0]) & 8'h8f))
        else $error("control outputs differ from written word");
    a_sync_bit: assert property (wr_ctl_ff && hwdata[CTL_SYNC] && sync_n
        |=> filter_sync_pulse ##1 !filter_sync_pulse)
        else $error("sync bit did not give a one-cycle pulse");
    a_sync_restart: assert property (filter_sync_pulse
        |-> ##[1:2] !filter_valid_flag)
        else $error("valid flag survived a sync");
    a_power_hold: assert property (power_down_bit && !filter_valid_flag
        |=> !filter_valid_flag)
        else $error("valid flag rose while powered down");
    a_rdata_upper: assert property (rd_ff |-> hrdata[31:16] == 16'h0)
        else $error("upper read data not zero");
    a_ctl_reserved: assert property (rd_ctl_ff
        |-> (hrdata[15:0] & ~CTL_WRITE_MASK) == 16'h0)
        else $error("reserved control bits read non-zero");
    a_status_mirror: assert property (rd_sts_ff
        |-> hrdata[STS_SETTLED] == $past(filter_valid_flag)
        && hrdata[STS_LOW_POWER] == $past(low_power_flag))
        else $error("status bits do not mirror flags");
    c_sync_bit: cover property (wr_ctl_ff && hwdata[CTL_SYNC]);
    c_settled: cover property ($rose(filter_valid_flag));
    c_status: cover property (rd_sts_ff);
endmodule // asc_control_sva
bind asc_control asc_control_sva asc_control_sva_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .sync_n, .gain_value,
    .threshold_value, .filter_valid_flag, .power_down_bit, .low_power_flag, .ref_bypass,
    .ref_buffer_off, .amplifier_disable, .filter_sync_pulse);
`default_nettype wire

// ===== verification/asc_host_model.sv
// host model: external sync pin and conversion data source
`timescale 1ns/10ps
`default_nettype none
module asc_host_model
#(
    parameter int SYNC_LOW = 6
)
(
    input  wire logic        hclk,
    input  wire logic        fire,
    output logic             sync_n,
    output logic      [15:0] conv_result,
    output logic             overrange_in,
    output logic             dec_rate_128
);
    int cnt_ff;
    // pin idles high when no sync is wanted
    assign sync_n       = (cnt_ff == 0);
    assign conv_result  = 16'h5a3c;
    assign overrange_in = 1'b0;
    assign dec_rate_128 = 1'b1;
    // pulse launched at a rising edge, held low well past the pin filter
    always_ff @(posedge hclk)
    begin
        cnt_ff <= (cnt_ff != 0) ? cnt_ff - 1 : (fire ? SYNC_LOW : 0);
    end
endmodule // asc_host_model
`default_nettype wire

// ===== verification/asc_control_bench.sv
// testbench: register access and start-up sequencing of the converter control block
`timescale 1ns/10ps
`default_nettype none
module asc_control_bench
    import asc_pkg::*;
;
    localparam int          SETTLE = 20;
    localparam logic        PART   = 1'b1; // arbitrary value
    localparam logic [31:0] STS    = {16'h0, PART, 15'h0} | 32'(STS_FIXED) | 32'h1;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, fire = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'h0;
    logic [15:0] conv_result, gain_value, threshold_value;
    logic        hready, hresp, sync_n, overrange_in, dec_rate_128, filter_valid_flag;
    logic        power_down_bit, low_power_flag, ref_bypass, ref_buffer_off;
    logic        amplifier_disable, filter_sync_pulse;
    int          miscompares = 0;
    int          checks = 0;
    logic [31:0] sel_tab [3] = '{32'h4000, 32'h2000, 32'h0800};
    logic [31:0] exp_tab [3] = '{32'hfff0, 32'h1234, STS | 32'h400};
    asc_control #(.SETTLE_CNT(SETTLE), .PART_BIT(PART)) asc_control_i (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready),
        .hresp, .sync_n, .overrange_in, .dec_rate_128, .conv_result, .gain_value,
        .threshold_value, .filter_valid_flag, .power_down_bit, .low_power_flag, .ref_bypass,
        .ref_buffer_off, .amplifier_disable, .filter_sync_pulse);
    asc_host_model asc_host_model_i (.hclk, .fire, .sync_n, .conv_result, .overrange_in,
        .dec_rate_128);
    always #20 hclk = ~hclk;
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask
    task automatic print_verdict;
        if (miscompares == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rdc(32'h8, STS);
        rdc(32'h4, 32'h0);
        rdc(32'h10, 32'(RST_GAIN));
        rdc(32'h14, 32'(RST_THRESHOLD));
        rdc(32'h3c, 32'h0);
        rdc(32'h1c, 32'h1);
        repeat (SETTLE + 8) @(posedge hclk);
        rdc(32'h8, STS | 32'h400);
        bus(32'h10, 1'b1, 32'habcd1234);
        bus(32'h14, 1'b1, 32'h0000fff0);
        bus(32'h3c, 1'b1, 32'hffffffff);
        rdc(32'h10, 32'h1234);
        rdc(32'h14, 32'hfff0);
        chk({16'h0, threshold_value}, 32'hfff0);
        rdc(32'h3c, 32'h0);
        bus(32'h4, 1'b1, 32'h95ff);
        rdc(32'h4, 32'h8f);
        rdc(32'h8, STS | 32'h618);
        bus(32'h4, 1'b1, 32'h0);
        bus(32'h4, 1'b1, 32'h200);
        rdc(32'h4, 32'h0);
        rdc(32'h8, STS);
        // power-down freezes the settling count, so the flag stays low
        bus(32'h4, 1'b1, 32'h8);
        repeat (SETTLE + 8) @(posedge hclk);
        rdc(32'h8, STS);
        bus(32'h4, 1'b1, 32'h0);
        repeat (SETTLE + 8) @(posedge hclk);
        rdc(32'h8, STS | 32'h400);
        for (int i = 0; i < 3; i++)
        begin
            bus(32'h4, 1'b1, sel_tab[i]);
            rdc(32'h4, 32'h0);
            rdc(32'h18, exp_tab[i]);
            rdc(32'h18, 32'h5a3c);
        end
        @(posedge hclk);
        fire <= 1'b1;
        @(posedge hclk);
        fire <= 1'b0;
        repeat (8) @(posedge hclk);
        chk({31'h0, filter_valid_flag}, 32'h0);
        repeat (SETTLE + 12) @(posedge hclk);
        chk({31'h0, filter_valid_flag}, 32'h1);
        bus(32'h4, 1'b1, 32'h8f);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({gain_value, 14'h0, power_down_bit, filter_valid_flag}, 32'ha0000000);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rdc(32'h4, 32'h0);
        rdc(32'h14, 32'(RST_THRESHOLD));
        print_verdict;
    end
    initial
    begin
        repeat (5000) @(posedge hclk);
        miscompares++;
        print_verdict;
    end
endmodule // asc_control_bench
`default_nettype wire
